// ### pkg/mcu_exec_consts.vh
`ifndef MCU_EXEC_CONSTS_VH
`define MCU_EXEC_CONSTS_VH

// Instruction codes presented on the opcode port.
`define OP_NOP      5'h00
`define OP_JMP      5'h01
`define OP_CALL     5'h02
`define OP_RET      5'h03
`define OP_RET_IMM  5'h04
`define OP_INTERRUPT_RETURN     5'h05
`define OP_SZ       5'h06
`define OP_SZA      5'h07
`define OP_SZ_BIT   5'h08
`define OP_SNZ_BIT  5'h09
`define OP_SIZ      5'h0a
`define OP_SDZ      5'h0b
`define OP_INCREMENT_TO_ACC_SKIP     5'h0c
`define OP_DECREMENT_TO_ACC_SKIP     5'h0d
`define OP_TRD_PAGE 5'h0e
`define OP_TRD_LAST 5'h0f
`define OP_CLR_WDT  5'h10
`define OP_WDT_PRE1 5'h11
`define OP_WDT_PRE2 5'h12
`define OP_SWAP     5'h13
`define OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR    5'h14
`define OP_HALT     5'h15
`define OP_ADD      5'h16
`define OP_ADD_IMM  5'h17
`define OP_SUM_INTO_MEMORY     5'h18
`define OP_ADC      5'h19
`define OP_ADD_WITH_CARRY_TO_MEMORY     5'h1a

// Register port map.
`define REG_STATUS  3'h0
`define REG_ACC     3'h1
`define REG_TBL_LO  3'h2
`define REG_TBL_HI  3'h3
`define REG_TBL_RES 3'h4
`define REG_CTRL    3'h5

// Status and control field positions.
`define FLG_C   0
`define FLG_AC  1
`define FLG_Z   2
`define FLG_OV  3
`define FLG_PDF 4
`define FLG_TO  5
`define FLG_SW_MASK 6'h0f
`define CTRL_TABLE_POINTER_HIGH 0

// Timing and addresses.
`define CLKS_PER_CYCLE 3'h4
`define PCL_ADDR       8'h06
`define LAST_PAGE      4'hf

`endif

// ### rtl/mcu_exec.v
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mcu_exec_consts.vh"
module mcu_exec (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [2:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        issue,
    input  wire [4:0]  opcode,
    input  wire [7:0]  mem_addr,
    input  wire [7:0]  mem_byte,
    input  wire [7:0]  immediate,
    input  wire [2:0]  bit_index,
    input  wire [11:0] target,
    input  wire [11:0] pc_next,
    input  wire [3:0]  pc_page,
    input  wire [14:0] rom_data,
    input  wire        wdt_timeout,
    input  wire        wake,
    output reg         busy,
    output reg         done,
    output reg         skip_next,
    output reg  [11:0] rom_addr,
    output reg         mem_we,
    output reg  [7:0]  mem_waddr,
    output reg  [7:0]  mem_wdata,
    output reg         pc_load,
    output reg  [11:0] pc_target,
    output reg         stack_push,
    output reg         stack_pop,
    output reg  [11:0] push_value,
    output reg  [7:0]  acc,
    output reg         wdt_clear,
    output reg         halted,
    output reg  [6:0]  table_result_high_byte
);

    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    reg        state;
    reg [3:0]  clk_cnt;
    reg [3:0]  last_cnt;
    reg [4:0]  op_r;
    reg [5:0]  flags;
    reg [7:0]  table_pointer_low;
    reg [3:0]  table_pointer_high;
    reg        table_pointer_high_enable;
    reg        pre_first;
    reg        pre_second;

    // Sum of two bytes and a carry: {ov, ac, c, sum}.
    function [10:0] add8;
        input [7:0] a;
        input [7:0] b;
        input       cin;
        reg   [8:0] s;
        reg   [4:0] h;
        begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            add8 = {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
        end
    endfunction

    // Opcodes whose result lands in data memory at the given address.
    function writes_mem;
        input [4:0] op;
        begin
            case (op)
                `OP_SIZ, `OP_SDZ, `OP_TRD_PAGE, `OP_TRD_LAST,
                `OP_SWAP, `OP_SUM_INTO_MEMORY, `OP_ADD_WITH_CARRY_TO_MEMORY: writes_mem = 1'b1;
                default: writes_mem = 1'b0;
            endcase
        end
    endfunction

    reg [7:0]  next_acc;
    reg [5:0]  next_flags;
    reg        next_we;
    reg [7:0]  next_wdata;
    reg        next_skip;
    reg        next_pc_load;
    reg [11:0] next_target;
    reg        next_push;
    reg        next_pop;
    reg [2:0]  next_cycles;
    reg        next_wdt_clear;
    reg        next_pre_first;
    reg        next_pre_second;
    reg [10:0] sum;
    reg [7:0]  inc_val;
    reg [7:0]  dec_val;

    // Decode and evaluate the instruction in the clock it is issued.
    always @* begin
        next_acc        = acc;
        next_flags      = flags;
        next_we         = 1'b0;
        next_wdata      = mem_byte;
        next_skip       = 1'b0;
        next_pc_load    = 1'b0;
        next_target     = target;
        next_push       = 1'b0;
        next_pop        = 1'b0;
        next_cycles     = 3'h1;
        next_wdt_clear  = 1'b0;
        next_pre_first  = pre_first;
        next_pre_second = pre_second;
        inc_val         = mem_byte + 8'h01;
        dec_val         = mem_byte - 8'h01;
        sum             = add8(acc, mem_byte, 1'b0);
        case (opcode)
            `OP_JMP: begin
                next_pc_load = 1'b1;
                next_cycles  = 3'h2;
            end
            `OP_CALL: begin
                next_pc_load = 1'b1;
                next_push    = 1'b1;
                next_cycles  = 3'h2;
            end
            `OP_RET, `OP_INTERRUPT_RETURN: begin
                next_pop    = 1'b1;
                next_cycles = 3'h2;
            end
            `OP_RET_IMM: begin
                next_pop    = 1'b1;
                next_acc    = immediate;
                next_cycles = 3'h2;
            end
            `OP_SZ: next_skip = (mem_byte == 8'h00);
            `OP_SZA: begin
                next_acc  = mem_byte;
                next_skip = (mem_byte == 8'h00);
            end
            `OP_SZ_BIT:  next_skip = ~mem_byte[bit_index];
            `OP_SNZ_BIT: next_skip = mem_byte[bit_index];
            `OP_SIZ: begin
                next_we    = 1'b1;
                next_wdata = inc_val;
                next_skip  = (inc_val == 8'h00);
            end
            `OP_SDZ: begin
                next_we    = 1'b1;
                next_wdata = dec_val;
                next_skip  = (dec_val == 8'h00);
            end
            `OP_INCREMENT_TO_ACC_SKIP: begin
                next_acc  = inc_val;
                next_skip = (inc_val == 8'h00);
            end
            `OP_DECREMENT_TO_ACC_SKIP: begin
                next_acc  = dec_val;
                next_skip = (dec_val == 8'h00);
            end
            `OP_TRD_PAGE, `OP_TRD_LAST: next_cycles = 3'h2;
            `OP_CLR_WDT: begin
                next_wdt_clear     = 1'b1;
                next_flags[`FLG_TO]  = 1'b0;
                next_flags[`FLG_PDF] = 1'b0;
                next_pre_first     = 1'b0;
                next_pre_second    = 1'b0;
            end
            `OP_WDT_PRE1: begin
                // Only the pair clears; a lone pre-clear just marks itself.
                if (pre_second) begin
                    next_wdt_clear       = 1'b1;
                    next_flags[`FLG_TO]  = 1'b0;
                    next_flags[`FLG_PDF] = 1'b0;
                    next_pre_first       = 1'b0;
                    next_pre_second      = 1'b0;
                end else begin
                    next_pre_first = 1'b1;
                end
            end
            `OP_WDT_PRE2: begin
                if (pre_first) begin
                    next_wdt_clear       = 1'b1;
                    next_flags[`FLG_TO]  = 1'b0;
                    next_flags[`FLG_PDF] = 1'b0;
                    next_pre_first       = 1'b0;
                    next_pre_second      = 1'b0;
                end else begin
                    next_pre_second = 1'b1;
                end
            end
            `OP_SWAP: begin
                next_we    = 1'b1;
                next_wdata = {mem_byte[3:0], mem_byte[7:4]};
            end
            `OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR: next_acc = {mem_byte[3:0], mem_byte[7:4]};
            `OP_HALT: begin
                next_wdt_clear       = 1'b1;
                next_flags[`FLG_PDF] = 1'b1;
                next_flags[`FLG_TO]  = 1'b0;
                next_pre_first       = 1'b0;
                next_pre_second      = 1'b0;
            end
            `OP_ADD, `OP_ADC, `OP_ADD_IMM, `OP_SUM_INTO_MEMORY, `OP_ADD_WITH_CARRY_TO_MEMORY: begin
                if (opcode == `OP_ADD_IMM) begin
                    sum = add8(acc, immediate, 1'b0);
                end else if (opcode == `OP_ADC || opcode == `OP_ADD_WITH_CARRY_TO_MEMORY) begin
                    sum = add8(acc, mem_byte, flags[`FLG_C]);
                end
                next_flags[`FLG_C]  = sum[8];
                next_flags[`FLG_AC] = sum[9];
                next_flags[`FLG_OV] = sum[10];
                next_flags[`FLG_Z]  = (sum[7:0] == 8'h00);
                if (opcode == `OP_SUM_INTO_MEMORY || opcode == `OP_ADD_WITH_CARRY_TO_MEMORY) begin
                    next_we    = 1'b1;
                    next_wdata = sum[7:0];
                end else begin
                    next_acc = sum[7:0];
                end
            end
            default: next_cycles = 3'h1;
        endcase
        // Penalties stack on the listed cycle count, one cycle each.
        if (writes_mem(opcode) && mem_addr == `PCL_ADDR) begin
            next_cycles = next_cycles + 3'h1;
        end
        if (next_skip) begin
            next_cycles = next_cycles + 3'h1;
        end
    end

    wire start    = (state == ST_IDLE) && issue && !halted;
    wire is_table = (op_r == `OP_TRD_PAGE) || (op_r == `OP_TRD_LAST);
    wire finish   = (state == ST_EXEC) && (clk_cnt == last_cnt);

    // Sequencer: counts four clocks per instruction cycle.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            clk_cnt  <= 4'h0;
            last_cnt <= 4'h0;
            op_r     <= `OP_NOP;
            done     <= 1'b0;
            busy     <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state    <= ST_EXEC;
                        clk_cnt  <= 4'h0;
                        op_r     <= opcode;
                        last_cnt <= {1'b0, next_cycles} * {1'b0, `CLKS_PER_CYCLE} - 4'h1;
                    end
                end
                ST_EXEC: begin
                    clk_cnt <= clk_cnt + 4'h1;
                    if (finish) begin
                        state <= ST_IDLE;
                        done  <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            busy <= start || (state == ST_EXEC && !finish) ||
                    (halted && !wake) || (finish && op_r == `OP_HALT);
        end
    end

    // Results of the instruction, plus software access to the registers.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc                    <= 8'h00;
            flags                  <= 6'h00;
            table_pointer_low      <= 8'h00;
            table_pointer_high     <= 4'h0;
            table_pointer_high_enable            <= 1'b0;
            pre_first              <= 1'b0;
            pre_second             <= 1'b0;
            table_result_high_byte <= 7'h00;
            skip_next              <= 1'b0;
            rom_addr               <= 12'h000;
            mem_we                 <= 1'b0;
            mem_waddr              <= 8'h00;
            mem_wdata              <= 8'h00;
            pc_load                <= 1'b0;
            pc_target              <= 12'h000;
            stack_push             <= 1'b0;
            stack_pop              <= 1'b0;
            push_value             <= 12'h000;
            wdt_clear              <= 1'b0;
            halted                 <= 1'b0;
            reg_rdata              <= 8'h00;
        end else begin
            mem_we     <= 1'b0;
            pc_load    <= 1'b0;
            stack_push <= 1'b0;
            stack_pop  <= 1'b0;
            wdt_clear  <= 1'b0;
            reg_rdata  <= 8'h00;
            // Software writes first, so an instruction in the same clock wins.
            if (reg_wr) begin
                case (reg_addr)
                    `REG_STATUS: flags <= (flags & ~`FLG_SW_MASK) |
                                          (reg_wdata[5:0] & `FLG_SW_MASK);
                    `REG_ACC:    acc <= reg_wdata;
                    `REG_TBL_LO: table_pointer_low <= reg_wdata;
                    `REG_TBL_HI: table_pointer_high <= reg_wdata[3:0];
                    `REG_CTRL:   table_pointer_high_enable <= reg_wdata[`CTRL_TABLE_POINTER_HIGH];
                    default: ;
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `REG_STATUS:  reg_rdata <= {2'b00, flags};
                    `REG_ACC:     reg_rdata <= acc;
                    `REG_TBL_LO:  reg_rdata <= table_pointer_low;
                    `REG_TBL_HI:  reg_rdata <= {4'h0, table_pointer_high};
                    `REG_TBL_RES: reg_rdata <= {1'b0, table_result_high_byte};
                    `REG_CTRL:    reg_rdata <= {5'h00, pre_second, pre_first, table_pointer_high_enable};
                    default:      reg_rdata <= 8'h00;
                endcase
            end
            if (start) begin
                acc        <= next_acc;
                flags      <= next_flags;
                pre_first  <= next_pre_first;
                pre_second <= next_pre_second;
                skip_next  <= next_skip;
                mem_we     <= next_we;
                mem_waddr  <= mem_addr;
                mem_wdata  <= next_wdata;
                pc_load    <= next_pc_load;
                pc_target  <= next_target;
                stack_push <= next_push;
                stack_pop  <= next_pop;
                push_value <= pc_next;
                wdt_clear  <= next_wdt_clear;
                // The ROM answers one clock later, so the address goes out now.
                if (opcode == `OP_TRD_LAST) begin
                    rom_addr <= {`LAST_PAGE, table_pointer_low};
                end else if (table_pointer_high_enable) begin
                    rom_addr <= {table_pointer_high, table_pointer_low};
                end else begin
                    rom_addr <= {pc_page, table_pointer_low};
                end
            end
            // Table word arrives in the first execute clock.
            if (state == ST_EXEC && clk_cnt == 4'h0 && is_table) begin
                mem_we                 <= 1'b1;
                mem_wdata              <= rom_data[7:0];
                table_result_high_byte <= rom_data[14:8];
            end
            // Power-down starts when the halt's single cycle ends.
            if (finish && op_r == `OP_HALT) begin
                halted <= 1'b1;
            end else if (wake) begin
                halted <= 1'b0;
            end
            // A timeout event beats any clear in the same clock.
            if (wdt_timeout) begin
                flags[`FLG_TO] <= 1'b1;
            end
        end
    end

endmodule // mcu_exec
`default_nettype wire

// ### bench/mcu_exec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcu_exec_consts.vh"
module mcu_exec_asserts (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        issue,
    input wire logic [4:0]  opcode,
    input wire logic [7:0]  mem_addr,
    input wire logic [7:0]  mem_byte,
    input wire logic [7:0]  immediate,
    input wire logic [11:0] target,
    input wire logic [11:0] pc_next,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        skip_next,
    input wire logic        mem_we,
    input wire logic [7:0]  mem_waddr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        stack_push,
    input wire logic [11:0] push_value,
    input wire logic        pc_load,
    input wire logic [11:0] pc_target,
    input wire logic        stack_pop,
    input wire logic        wdt_clear,
    input wire logic [7:0]  acc,
    input wire logic        halted
);
    logic [7:0]  prev_mem;
    logic [7:0]  prev_acc;
    logic [7:0]  prev_imm;
    logic [7:0]  prev_addr;
    logic [11:0] prev_pcn;
    logic [11:0] prev_tgt;
    wire         take = issue && !busy && !halted;

    // Operands are kept one edge so each result can be tied to what was offered.
    always_ff @(posedge mclk) begin
        prev_mem  <= mem_byte;
        prev_acc  <= acc;
        prev_imm  <= immediate;
        prev_addr <= mem_addr;
        prev_pcn  <= pc_next;
        prev_tgt  <= target;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_jump_two_cycles:
        assert property (take && opcode == `OP_JMP |=> busy [*8] ##1 (done && !busy))
        else $error("Jump did not end eight clocks after issue.");
    a_skip_extends:
        assert property (take && opcode == `OP_SZ && mem_byte == 8'h00 |=> skip_next ##8 done)
        else $error("Taken skip did not last eight clocks.");
    a_pcl_penalty:
        assert property (take && opcode == `OP_SUM_INTO_MEMORY && mem_addr == `PCL_ADDR |=> !done [*8] ##1 done)
        else $error("Write to the low program counter byte was not extended.");
    a_siz_writeback:
        assert property (take && opcode == `OP_SIZ |=> mem_we && mem_wdata == prev_mem + 8'h01
            && mem_waddr == prev_addr && skip_next == (prev_mem == 8'hff))
        else $error("Increment and skip wrote or skipped wrongly.");
    a_nibble_exchange_to_accumulator_value:
        assert property (take && opcode == `OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR |=> acc == {prev_mem[3:0], prev_mem[7:4]} ##4 done)
        else $error("Nibble exchange into accumulator is wrong.");
    a_imm_add:
        assert property (take && opcode == `OP_ADD_IMM |=> acc == prev_acc + prev_imm)
        else $error("Immediate add result is wrong.");
    a_call_push:
        assert property (take && opcode == `OP_CALL |=> stack_push && push_value == prev_pcn)
        else $error("Call did not push the following address.");
    a_halt_enter:
        assert property (take && opcode == `OP_HALT |=> !halted [*4] ##1 halted)
        else $error("Halt did not take effect after one cycle.");
    a_jump_target:
        assert property (take && (opcode == `OP_JMP || opcode == `OP_CALL) |=> pc_load
            && pc_target == prev_tgt && !stack_pop)
        else $error("Jump or call did not load its target.");
    a_return_pop:
        assert property (take && (opcode == `OP_RET || opcode == `OP_INTERRUPT_RETURN
            || opcode == `OP_RET_IMM) |=> stack_pop && !stack_push && !pc_load)
        else $error("Return did not pop the stack.");
    a_halt_wdt:
        assert property (take && opcode == `OP_HALT |=> wdt_clear ##1 !wdt_clear)
        else $error("Halt did not clear the watchdog.");
endmodule // mcu_exec_asserts

bind mcu_exec mcu_exec_asserts chk_u (.mclk, .rst_n, .issue, .opcode, .mem_addr, .mem_byte,
    .immediate, .target, .pc_next, .busy, .done, .skip_next, .mem_we, .mem_waddr, .mem_wdata,
    .stack_push, .push_value, .pc_load, .pc_target, .stack_pop, .wdt_clear, .acc, .halted);
`default_nettype wire

// ### bench/mcu_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_far_side (
    input  wire logic        mclk,
    input  wire logic [11:0] rom_addr,
    output logic      [14:0] rom_data,
    input  wire logic        mem_we,
    input  wire logic [7:0]  mem_waddr,
    input  wire logic [7:0]  mem_wdata
);
    logic [7:0] ram [0:255];

    // Each ROM word is a function of its address, so the bench can predict any fetch.
    assign rom_data = {rom_addr[11:5], rom_addr[7:0] ^ 8'ha5};

    // Data memory takes the write pulse on the clock edge, as the real array does.
    always @(posedge mclk) begin
        if (mem_we) begin
            ram[mem_waddr] <= mem_wdata;
        end
    end
endmodule // mcu_far_side
`default_nettype wire

// ### bench/mcu_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcu_exec_consts.vh"
module mcu_exec_tb;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        issue = 1'b0;
    logic [4:0]  opcode = 5'h00;
    logic [7:0]  mem_addr = 8'h00;
    logic [7:0]  mem_byte = 8'h00;
    logic [7:0]  immediate = 8'h00;
    logic [2:0]  bit_index = 3'h0;
    logic [11:0] target = 12'h3a7;
    logic [11:0] pc_next = 12'h122;
    logic [3:0]  pc_page = 4'h9;
    logic        wdt_timeout = 1'b0;
    logic        wake = 1'b0;
    wire  [7:0]  reg_rdata, acc, mem_waddr, mem_wdata;
    wire  [14:0] rom_data;
    wire  [11:0] rom_addr, pc_target, push_value;
    wire  [6:0]  tbl_high;
    wire         busy, done, skip_next, mem_we, pc_load, stack_push, stack_pop, wdt_clear, halted;
    int          miscompares = 0;
    int          checks = 0;
    int          n;
    logic [4:0]  sop [10] = '{`OP_SZ, `OP_SZ, `OP_SZA, `OP_SZ_BIT, `OP_SZ_BIT, `OP_SNZ_BIT,
                              `OP_SIZ, `OP_SDZ, `OP_INCREMENT_TO_ACC_SKIP, `OP_DECREMENT_TO_ACC_SKIP};
    logic [7:0]  sm [10] = '{8'h01, 8'h00, 8'h00, 8'hf7, 8'h08, 8'h80, 8'hff, 8'h01, 8'h05, 8'h01};
    logic [7:0]  sbit [10] = '{8'h0, 8'h0, 8'h0, 8'h3, 8'h3, 8'h7, 8'h0, 8'h0, 8'h0, 8'h0};
    int          sclk [10] = '{4, 8, 8, 8, 4, 8, 8, 8, 4, 8};
    logic [4:0]  bop [5] = '{`OP_JMP, `OP_CALL, `OP_RET, `OP_RET_IMM, `OP_INTERRUPT_RETURN};

    mcu_exec dut_u (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .issue,
        .opcode, .mem_addr, .mem_byte, .immediate, .bit_index, .target, .pc_next, .pc_page,
        .rom_data, .wdt_timeout, .wake, .busy, .done, .skip_next, .rom_addr, .mem_we, .mem_waddr,
        .mem_wdata, .pc_load, .pc_target, .stack_push, .stack_pop, .push_value, .acc,
        .wdt_clear, .halted, .table_result_high_byte(tbl_high));
    mcu_far_side far_u (.mclk, .rom_addr, .rom_data, .mem_we, .mem_waddr, .mem_wdata);

    // Free-running system clock at 40 MHz.
    always #12.5 mclk = ~mclk;

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so it is taken mid-cycle there.
    task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    task automatic expect_regs(input logic [7:0] a, input logic [5:0] st);
        logic [7:0] v;
        reg_read(`REG_ACC, v);
        check("acc", a, v);
        reg_read(`REG_STATUS, v);
        check("status", {2'b00, st}, v);
    endtask

    // Issues one instruction and counts clocks until its completion pulse.
    task automatic run(input logic [4:0] op, input logic [7:0] m, input logic [7:0] a,
                       input logic [7:0] imm, input int clocks);
        @(posedge mclk);
        opcode <= op;
        mem_byte <= m;
        mem_addr <= a;
        immediate <= imm;
        bit_index <= imm[2:0];
        issue <= 1'b1;
        @(posedge mclk);
        issue <= 1'b0;
        // Counts the clocks in which done is still low after the issue edge: 4N for N cycles.
        n = 0;
        @(negedge mclk);
        while (done !== 1'b1 && n < 40) begin
            n++;
            @(negedge mclk);
        end
        check("instruction clocks", clocks, n);
    endtask

    task automatic table_case(input logic [4:0] op, input logic [7:0] ctl, input logic [7:0] dst,
                              input logic [11:0] ra);
        reg_write(`REG_CTRL, ctl);
        run(op, 8'h00, dst, 8'h00, 8);
        check("rom address", ra, rom_addr);
        check("table low", ra[7:0] ^ 8'ha5, far_u.ram[dst]);
        check("table high", ra[11:5], tbl_high);
    endtask

    task automatic tally_and_finish;
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // A hang is cut short well past the expected run of a few hundred clocks.
    initial begin
        #300000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] v;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        reg_read(3'h7, v);
        check("unmapped", 8'h00, v);
        expect_regs(8'h00, 6'h00);
        reg_write(`REG_ACC, 8'h78);
        run(`OP_ADD_IMM, 8'h00, 8'h10, 8'h08, 4);
        expect_regs(8'h80, 6'h0a);
        reg_write(`REG_STATUS, 8'h01);
        reg_write(`REG_ACC, 8'hff);
        run(`OP_ADC, 8'h00, 8'h10, 8'h00, 4);
        expect_regs(8'h00, 6'h07);
        reg_write(`REG_ACC, 8'h10);
        run(`OP_ADD_WITH_CARRY_TO_MEMORY, 8'h20, 8'h21, 8'h00, 4);
        check("add_with_carry_to_memory memory", 8'h31, far_u.ram[8'h21]);
        expect_regs(8'h10, 6'h00);
        reg_write(`REG_ACC, 8'h80);
        run(`OP_ADD, 8'h80, 8'h10, 8'h00, 4);
        expect_regs(8'h00, 6'h0d);
        reg_write(`REG_ACC, 8'h05);
        run(`OP_SUM_INTO_MEMORY, 8'h0b, 8'h22, 8'h00, 4);
        check("sum_into_memory memory", 8'h10, far_u.ram[8'h22]);
        expect_regs(8'h05, 6'h02);
        run(`OP_SUM_INTO_MEMORY, 8'h00, `PCL_ADDR, 8'h00, 8);
        for (int i = 0; i < 10; i++) begin
            run(sop[i], sm[i], 8'h30 + i[7:0], sbit[i], sclk[i]);
            check("skip flag", sclk[i] == 8, skip_next);
        end
        check("siz memory", 8'h00, far_u.ram[8'h36]);
        check("sdz memory", 8'h00, far_u.ram[8'h37]);
        run(`OP_SIZ, 8'hff, `PCL_ADDR, 8'h00, 12);
        reg_write(`REG_STATUS, 8'h0f);
        for (int i = 0; i < 5; i++) begin
            run(bop[i], 8'h00, 8'h00, 8'h5a, 8);
        end
        expect_regs(8'h5a, 6'h0f);
        reg_write(`REG_TBL_LO, 8'h34);
        reg_write(`REG_TBL_HI, 8'h05);
        table_case(`OP_TRD_PAGE, 8'h01, 8'h40, 12'h534);
        table_case(`OP_TRD_PAGE, 8'h00, 8'h41, 12'h934);
        table_case(`OP_TRD_LAST, 8'h00, 8'h42, 12'hf34);
        @(posedge mclk);
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
        run(`OP_WDT_PRE1, 8'h00, 8'h00, 8'h00, 4);
        expect_regs(8'h5a, 6'h2f);
        run(`OP_WDT_PRE2, 8'h00, 8'h00, 8'h00, 4);
        expect_regs(8'h5a, 6'h0f);
        run(`OP_HALT, 8'h00, 8'h00, 8'h00, 4);
        @(negedge mclk);
        check("halted", 1'b1, halted);
        expect_regs(8'h5a, 6'h1f);
        @(posedge mclk);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        repeat (2) @(negedge mclk);
        check("woken", 1'b0, halted);
        run(`OP_SWAP, 8'h3c, 8'h50, 8'h00, 4);
        check("swap memory", 8'hc3, far_u.ram[8'h50]);
        run(`OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR, 8'h12, 8'h51, 8'h00, 4);
        expect_regs(8'h21, 6'h1f);
        run(`OP_CLR_WDT, 8'h00, 8'h00, 8'h00, 4);
        expect_regs(8'h21, 6'h0f);
        run(`OP_NOP, 8'h00, 8'h00, 8'h00, 4);
        tally_and_finish();
    end
endmodule // mcu_exec_tb
`default_nettype wire
